// ### verilog/cptag_regs.v
// TLB tag and page-size register group
`timescale 1ns/1ps
`default_nettype none
`include "cptag_defines.vh"
module cptag_regs #(
  parameter THREADS     = 1,
  parameter TW          = 1,
  parameter RELEASE6    = 1,
  parameter USER_PRESENT = 1,
  parameter DBG_PRESENT = 1,
  parameter MAP_IDENT_FIELD_BITS   = 32,
  parameter SP_IMPL     = 0,
  // Number of lowest mask bit pairs that are unsupported (release 6 only)
  parameter MIN_PAIRS_OFF = 0,
  // Mask bits above this pair count read zero
  parameter MAX_PAIRS   = 8
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rstn,
  // Coprocessor move port
  input  wire          mv_wr,
  input  wire          mv_rd,
  input  wire [4:0]    mv_regnum,
  input  wire [2:0]    mv_sel,
  input  wire [31:0]   mv_wdata,
  input  wire [TW-1:0] mv_thread,
  output reg  [31:0]   mv_rdata,
  output reg           mv_hit,
  // Mode and configuration
  input  wire          kernel_mode,
  input  wire          debug_mode_flag,
  input  wire          debug_perf_present_flag,
  input  wire          map_ident_select,
  input  wire          small_page_enable,
  input  wire [31:0]   hw_read_enable_reg,
  output wire          user_word_present_flag,
  // Hardware register read port
  input  wire          hwr_rd,
  input  wire [4:0]    hwr_index,
  input  wire          hwr_user_mode,
  input  wire [TW-1:0] hwr_thread,
  output reg  [31:0]   hwr_rdata,
  output reg           hwr_ok,
  // TLB side
  input  wire          tlb_read_instr,
  input  wire [31:0]   tlb_rd_map_ident_field,
  input  wire [31:0]   tlb_rd_pmask,
  input  wire [9:0]    address_space_tag,
  output wire          tlb_rd_load_address_space_tag,
  output wire [31:0]   tlb_tag,
  output wire [31:0]   tlb_wr_pmask,
  output wire [31:0]   debug_process_tag_out
);
  localparam [31:0] MAP_IDENT_FIELD_KEEP = (MAP_IDENT_FIELD_BITS >= 32) ? 32'hffff_ffff :
                                ((32'h0000_0001 << MAP_IDENT_FIELD_BITS) - 32'h0000_0001);
  localparam        SP_ON = (SP_IMPL != 0) && (RELEASE6 == 0);
  localparam        USER_ON = (RELEASE6 != 0) || (USER_PRESENT != 0);

  // Register select decode used by reads and writes
  function hit;
    input [4:0] rn;
    input [2:0] sl;
    input [4:0] wrn;
    input [2:0] wsl;
    begin
      hit = (rn == wrn) && (sl == wsl);
    end
  endfunction

  // Supported mask bits: pairs in [MIN_PAIRS_OFF, MAX_PAIRS)
  function [15:0] pairs_upto;
    input integer n;
    integer k;
    begin
      pairs_upto = 16'h0000;
      for (k = 0; k < 8; k = k + 1)
        if (k < n)
          pairs_upto[2*k +: 2] = 2'h3;
    end
  endfunction
  localparam [15:0] MASK_ONES = (RELEASE6 != 0) ? pairs_upto(MIN_PAIRS_OFF) : 16'h0000;
  localparam [15:0] MASK_RW   = pairs_upto(MAX_PAIRS) & ~MASK_ONES;

  wire sel_user  = hit(mv_regnum, mv_sel, `CPTAG_REGNUM_USER, `CPTAG_SEL_USER) && USER_ON;
  wire dbg_ok    = (DBG_PRESENT != 0) && debug_perf_present_flag
                   && kernel_mode && !debug_mode_flag;
  wire sel_dbg   = hit(mv_regnum, mv_sel, `CPTAG_REGNUM_DBG, `CPTAG_SEL_DBG) && dbg_ok;
  wire sel_map_ident_field  = hit(mv_regnum, mv_sel, `CPTAG_REGNUM_MAP_IDENT_FIELD, `CPTAG_SEL_MAP_IDENT_FIELD);
  wire sel_pmask = hit(mv_regnum, mv_sel, `CPTAG_REGNUM_PMASK, `CPTAG_SEL_PMASK);

  assign user_word_present_flag = USER_ON;

  // User-local words, one per thread
  wire [31:0] user_rd;
  wire [31:0] user_hw;
  cptag_user_bank #(.THREADS(THREADS), .TW(TW)) u_bank (
    .ref_clk   (ref_clk),
    .wr_en     (mv_wr && sel_user),
    .wr_thread (mv_thread),
    .wr_data   (mv_wdata),
    .rd_thread (mv_thread),
    .rd_data   (user_rd),
    .hw_thread (hwr_thread),
    .hw_data   (user_hw)
  );

  // Debug tag: no reset, feeds debug_process_tag_out and move reads
  reg [31:0] dbg_tag_r;
  always @(posedge ref_clk) begin
    if (mv_wr && sel_dbg)
      dbg_tag_r <= mv_wdata;
  end
  assign debug_process_tag_out = dbg_tag_r;

  // Map identifier
  reg [31:0] map_ident_field_r;
  reg [31:0] map_ident_field_nxt;
  always @* begin
    map_ident_field_nxt = map_ident_field_r;
    if (map_ident_select) begin
      if (tlb_read_instr)
        map_ident_field_nxt = tlb_rd_map_ident_field & MAP_IDENT_FIELD_KEEP;
      else if (mv_wr && sel_map_ident_field)
        map_ident_field_nxt = mv_wdata & MAP_IDENT_FIELD_KEEP;
    end
  end
  always @(posedge ref_clk) begin
    map_ident_field_r <= map_ident_field_nxt;
  end
  assign tlb_rd_load_address_space_tag = tlb_read_instr && !map_ident_select;
  assign tlb_tag = map_ident_select ? (map_ident_field_r & MAP_IDENT_FIELD_KEEP)
                                    : {22'h00_0000, address_space_tag};

  // Page mask
  reg  [15:0] mask_r;
  reg  [1:0]  small_page_mask_ext_r;
  wire        sp_act = SP_ON && small_page_enable;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_r  <= 16'h0000;
      small_page_mask_ext_r <= 2'h0;
    end else if (tlb_read_instr) begin
      mask_r  <= tlb_rd_pmask[`CPTAG_MASK_MSB:`CPTAG_MASK_LSB] & MASK_RW;
      small_page_mask_ext_r <= sp_act ? tlb_rd_pmask[`CPTAG_SMALL_PAGE_MASK_EXT_MSB:`CPTAG_SMALL_PAGE_MASK_EXT_LSB] : 2'h0;
    end else if (mv_wr && sel_pmask) begin
      mask_r  <= mv_wdata[`CPTAG_MASK_MSB:`CPTAG_MASK_LSB] & MASK_RW;
      small_page_mask_ext_r <= sp_act ? mv_wdata[`CPTAG_SMALL_PAGE_MASK_EXT_MSB:`CPTAG_SMALL_PAGE_MASK_EXT_LSB] : 2'h0;
    end
  end
  wire [15:0] mask_view  = mask_r | MASK_ONES;
  wire [1:0]  small_page_mask_ext_view = sp_act ? small_page_mask_ext_r : 2'h0;
  wire [31:0] pmask_read = {3'h0, mask_view, small_page_mask_ext_view, 11'h000};
  // TLB sees extension as 0b11 unless small pages active
  assign tlb_wr_pmask = {3'h0, mask_view,
                         (sp_act ? small_page_mask_ext_r : `CPTAG_SMALL_PAGE_MASK_EXT_FORCED), 11'h000};

  // Move reads
  always @* begin
    mv_rdata = `CPTAG_ZERO32;
    mv_hit   = mv_rd || mv_wr;
    if (sel_user)
      mv_rdata = user_rd;
    else if (sel_dbg)
      mv_rdata = dbg_tag_r;
    else if (sel_map_ident_field)
      mv_rdata = map_ident_select ? (map_ident_field_r & MAP_IDENT_FIELD_KEEP) : `CPTAG_ZERO32;
    else if (sel_pmask)
      mv_rdata = pmask_read;
    else
      mv_hit = 1'b0;
    if (!mv_rd)
      mv_rdata = `CPTAG_ZERO32;
  end

  // Hardware register read of the user word
  always @* begin
    hwr_ok    = 1'b0;
    hwr_rdata = `CPTAG_ZERO32;
    if (hwr_rd && USER_ON && hwr_index == `CPTAG_HWR_USER_IDX &&
        (!hwr_user_mode || hw_read_enable_reg[`CPTAG_HWR_USER_IDX])) begin
      hwr_ok    = 1'b1;
      hwr_rdata = user_hw;
    end
  end
endmodule // cptag_regs
`default_nettype wire

// ### verilog/cptag_defines.vh
// Constants for the TLB tag and page-size register group
`ifndef CPTAG_DEFINES_VH
`define CPTAG_DEFINES_VH
`define CPTAG_REGNUM_USER      5'h04
`define CPTAG_SEL_USER         3'h2
`define CPTAG_REGNUM_DBG       5'h04
`define CPTAG_SEL_DBG          3'h4
`define CPTAG_REGNUM_MAP_IDENT_FIELD      5'h04
`define CPTAG_SEL_MAP_IDENT_FIELD         3'h5
`define CPTAG_REGNUM_PMASK     5'h05
`define CPTAG_SEL_PMASK        3'h0
`define CPTAG_HWR_USER_IDX     5'h1d
`define CPTAG_MASK_LSB         13
`define CPTAG_MASK_MSB         28
`define CPTAG_SMALL_PAGE_MASK_EXT_LSB        11
`define CPTAG_SMALL_PAGE_MASK_EXT_MSB        12
`define CPTAG_SMALL_PAGE_MASK_EXT_FORCED     2'h3
`define CPTAG_ZERO32           32'h0000_0000
`endif

// ### verilog/cptag_user_bank.v
// Per-thread bank of user-local words
`timescale 1ns/1ps
`default_nettype none
module cptag_user_bank #(
  parameter THREADS = 1,
  parameter TW      = 1
) (
  // Clock
  input  wire          ref_clk,
  // Write side
  input  wire          wr_en,
  input  wire [TW-1:0] wr_thread,
  input  wire [31:0]   wr_data,
  // Read side
  input  wire [TW-1:0] rd_thread,
  output wire [31:0]   rd_data,
  // Hardware register read side, own thread index
  input  wire [TW-1:0] hw_thread,
  output wire [31:0]   hw_data
);
  reg [31:0] word_r [0:THREADS-1];
  genvar g;
  generate
    for (g = 0; g < THREADS; g = g + 1) begin : g_thr
      localparam [TW-1:0] IDX = g;
      // No reset: contents undefined until software writes
      always @(posedge ref_clk) begin
        if (wr_en && wr_thread == IDX)
          word_r[g] <= wr_data;
      end
    end
  endgenerate
  assign rd_data = word_r[rd_thread];
  // Unprivileged read picks the word of the requesting thread
  assign hw_data = word_r[hw_thread];
endmodule // cptag_user_bank
`default_nettype wire

// ### testbench/cptag_regs_monitor.sv
// Checker for the TLB tag and page-size register group
`timescale 1ns/1ps
`default_nettype none
module cptag_regs_monitor (
  // Clock, reset and move port
  input wire logic        ref_clk, rstn, mv_wr, mv_rd, mv_hit,
  input wire logic [4:0]  mv_regnum,
  input wire logic [2:0]  mv_sel,
  input wire logic [31:0] mv_wdata, mv_rdata,
  // Modes, hardware read and TLB side
  input wire logic        kernel_mode, debug_mode_flag, map_ident_select, tlb_read_instr,
  input wire logic        tlb_rd_load_address_space_tag, hwr_rd, hwr_user_mode, hwr_ok,
  input wire logic [4:0]  hwr_index,
  input wire logic [9:0]  address_space_tag,
  input wire logic [31:0] hw_read_enable_reg, tlb_rd_map_ident_field, tlb_tag, tlb_wr_pmask
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire mm = mv_regnum == 5'h04 && mv_sel == 3'h5;
  wire pm = mv_regnum == 5'h05 && mv_sel == 3'h0;
  property p_mm_off; mv_rd && mm && !map_ident_select |-> mv_rdata == 32'h0000_0000; endproperty
  a_mm_off: assert property (p_mm_off) else $error("identifier not zero");
  property p_mm_wr; mv_wr && mm && map_ident_select && !tlb_read_instr ##1
    mv_rd && mm && map_ident_select |-> mv_rdata == $past(mv_wdata); endproperty
  a_mm_wr: assert property (p_mm_wr) else $error("identifier write lost");
  property p_tlb_read_instr; tlb_read_instr && map_ident_select ##1
    mv_rd && mm && map_ident_select |-> mv_rdata == $past(tlb_rd_map_ident_field); endproperty
  a_tlb_read_instr: assert property (p_tlb_read_instr) else $error("identifier not loaded");
  property p_address_space_tag; !map_ident_select |-> tlb_tag == {22'h00_0000, address_space_tag}; endproperty
  a_address_space_tag: assert property (p_address_space_tag) else $error("tag not zero-extended");
  property p_load; tlb_read_instr |-> tlb_rd_load_address_space_tag == !map_ident_select; endproperty
  a_load: assert property (p_load) else $error("both tags loaded");
  property p_pm_rsv; mv_rd && pm |-> mv_rdata[31:29] == 3'h0 && mv_rdata[12:0] == 13'h0000;
  endproperty
  a_pm_rsv: assert property (p_pm_rsv) else $error("mask reserved bits set");
  property p_pm_x; tlb_wr_pmask[12:11] == 2'h3; endproperty
  a_pm_x: assert property (p_pm_x) else $error("extension not forced");
  property p_hwr; hwr_rd && hwr_index == 5'h1d |->
    hwr_ok == (hw_read_enable_reg[29] || !hwr_user_mode); endproperty
  a_hwr: assert property (p_hwr) else $error("hardware read gate wrong");
  property p_dbg; mv_rd && mv_regnum == 5'h04 && mv_sel == 3'h4 &&
    (debug_mode_flag || !kernel_mode) |-> !mv_hit; endproperty
  a_dbg: assert property (p_dbg) else $error("debug tag reachable");
endmodule // cptag_regs_monitor
bind cptag_regs cptag_regs_monitor i_mon (.*);
`default_nettype wire

// ### testbench/cptag_tlb_model.sv
// TLB array stub: entry lines valid only in the read cycle
`timescale 1ns/1ps
`default_nettype none
module cptag_tlb_model (
  // Bench control
  input wire logic        rd_req,
  input wire logic [31:0] entry_map_ident_field,
  // Toward the register group
  output logic            tlb_read_instr,
  output logic [31:0]     tlb_rd_map_ident_field, tlb_rd_pmask,
  output logic [9:0]      address_space_tag
);
  assign tlb_read_instr = rd_req;
  assign tlb_rd_map_ident_field = rd_req ? entry_map_ident_field : ~entry_map_ident_field;
  assign tlb_rd_pmask = rd_req ? 32'h0000_6000 : 32'hffff_9fff;
  assign address_space_tag = 10'h2a5;
endmodule // cptag_tlb_model
`default_nettype wire

// ### testbench/cptag_regs_tb_top.sv
// Self-checking bench for the TLB tag and page-size register group
`timescale 1ns/1ps
`default_nettype none
module cptag_regs_tb_top;
  logic ref_clk = 0, rstn = 0, mv_wr = 0, mv_rd = 0, kernel_mode = 1, debug_mode_flag = 0;
  logic debug_perf_present_flag = 1, map_ident_select = 1, small_page_enable = 1, hwr_rd = 0;
  logic hwr_user_mode = 1, rd_req = 0, mv_thread = 0, hwr_thread = 0, hit_s;
  logic mv_hit, hwr_ok, user_word_present_flag, tlb_read_instr, tlb_rd_load_address_space_tag;
  logic [4:0] mv_regnum = 5'h00, hwr_index = 5'h1d;
  logic [2:0] mv_sel = 3'h0;
  logic [9:0] address_space_tag;
  logic [31:0] mv_wdata = 0, hw_read_enable_reg = 0, entry_map_ident_field = 0, mv_rdata, hwr_rdata;
  logic [31:0] tlb_tag, tlb_rd_map_ident_field, tlb_rd_pmask, tlb_wr_pmask, debug_process_tag_out;
  logic [31:0] pm [4] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_000f, 32'h0000_003f};
  int fails = 0, samples_checked = 0, cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  cptag_regs i_cptag_regs (.*);
  cptag_tlb_model i_cptag_tlb_model (.*);
  task chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] d);
    mv_regnum <= r;
    mv_sel <= s;
    mv_wdata <= d;
    mv_wr <= 1'b1;
    @(posedge ref_clk);
    mv_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] r, input logic [2:0] s, input logic [31:0] e);
    mv_regnum <= r;
    mv_sel <= s;
    mv_rd <= 1'b1;
    #1 chk(mv_rdata, e);
    hit_s = mv_hit;
    @(posedge ref_clk);
    mv_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task t_map_ident_field;
    wr(5'h04, 3'h5, 32'ha5a5_1234);
    rd(5'h04, 3'h5, 32'ha5a5_1234);
    chk(tlb_tag, 32'ha5a5_1234);
    map_ident_select <= 1'b0;
    wr(5'h04, 3'h5, 32'h0000_0077);
    rd(5'h04, 3'h5, 32'h0000_0000);
    chk(tlb_tag, 32'h0000_02a5);
    map_ident_select <= 1'b1;
    rd(5'h04, 3'h5, 32'ha5a5_1234);
    $display("t_map_ident_field done");
  endtask
  task t_tlb_read_instr;
    entry_map_ident_field <= 32'h0bad_f00d;
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
    rd(5'h04, 3'h5, 32'h0bad_f00d);
    rd(5'h05, 3'h0, 32'h0000_6000);
    wr(5'h04, 3'h5, 32'ha5a5_1234);
    @(posedge ref_clk);
    $display("t_tlb_read_instr done");
  endtask
  task t_pmask;
    wr(5'h05, 3'h0, 32'hffff_ffff);
    rd(5'h05, 3'h0, 32'h1fff_e000);
    chk(tlb_wr_pmask, 32'h1fff_f800);
    for (int i = 0; i < 4; i++) begin
      wr(5'h05, 3'h0, pm[i] << 13);
      rd(5'h05, 3'h0, pm[i] << 13);
    end
    $display("t_pmask done");
  endtask
  task t_user;
    wr(5'h04, 3'h2, 32'hc0de_0042);
    rd(5'h04, 3'h2, 32'hc0de_0042);
    chk({31'h0, user_word_present_flag}, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      hw_read_enable_reg <= k[0] ? 32'h2000_0000 : 32'h0000_0000;
      hwr_rd <= 1'b1;
      #1 chk({31'h0, hwr_ok}, {31'h0, k[0]});
      if (k == 1) chk(hwr_rdata, 32'hc0de_0042);
      @(posedge ref_clk);
    end
    hwr_rd <= 1'b0;
    $display("t_user done");
  endtask
  task t_dbg;
    wr(5'h04, 3'h4, 32'h1357_9bdf);
    rd(5'h04, 3'h4, 32'h1357_9bdf);
    chk({31'h0, hit_s}, 32'h0000_0001);
    chk(debug_process_tag_out, 32'h1357_9bdf);
    debug_mode_flag <= 1'b1;
    rd(5'h04, 3'h4, 32'h0000_0000);
    chk({31'h0, hit_s}, 32'h0000_0000);
    rd(5'h04, 3'h7, 32'h0000_0000);
    chk({31'h0, hit_s}, 32'h0000_0000);
    $display("t_dbg done");
  endtask
  task wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(5'h05, 3'h0, 32'h0000_0000);
    t_map_ident_field;
    t_tlb_read_instr;
    t_pmask;
    t_user;
    t_dbg;
    wrap_up;
  end
endmodule // cptag_regs_tb_top
`default_nettype wire
